// ===== usf_status_flags.sv
/*
  Status flags of an asynchronous serial interface with a Wishbone
  classic register slave: status, data buffer and control registers.
  Assumes the transmit and receive shifters outside hand over events
  as one-cycle pulses on i_clk, and bit ticks come from a divider.
*/
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module usf_status_flags
  import usf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_tx_load,
  input wire logic i_tx_busy,
  output logic [7:0] o_tx_data,
  output logic o_tx_wr,
  output logic o_tx_on,
  output logic o_break_req,
  output logic o_char9,
  input wire logic i_rxd,
  input wire logic i_bit_tick,
  input wire logic i_start_det,
  input wire logic i_stop_done,
  input wire logic i_smp_valid,
  input wire logic i_smp_start,
  input wire logic [6:0] i_smps,
  input wire logic i_rx_char,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_par_bit,
  input wire logic i_rx_stop_low
);
  // Bus state
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  // Control and data registers
  logic [7:0] ctl_r;
  logic [7:0] tx_data_r;
  logic tx_wr_r;
  logic [7:0] rx_data_r;
  // Status flags and their clear arming
  logic tx_buffer_empty_r, tc_r, rx_buffer_full_r, idle_r, ovr_r, nf_r, fe_r, pf_r;
  logic [7:0] arm_r;
  logic [7:0] arm_nxt;
  // Transmit work queued but not yet started
  logic queue_r;
  // Idle line tracking
  logic [3:0] idle_cnt_r;
  logic idle_en_r;
  logic idle_allow_r;
  // Noise accumulated over the character
  logic noise_acc_r;
  logic noisy_now;

  // Bus decode
  wire bus_req = i_wb_cyc & i_wb_stb;
  wire bus_fire = bus_req & ack_r;
  wire wr_fire = bus_fire & i_wb_we & i_wb_sel[0];
  wire rd_fire = bus_fire & ~i_wb_we;
  wire sel_stat = (i_wb_adr == USF_OFS_STATUS);
  wire sel_data = (i_wb_adr == USF_OFS_DATA);
  wire sel_ctl = (i_wb_adr == USF_OFS_CTRL);
  wire stat_rd = rd_fire & sel_stat;
  wire data_wr = wr_fire & sel_data;
  wire data_rd = rd_fire & sel_data;
  wire ctl_wr = wr_fire & sel_ctl;
  wire [7:0] wdat = i_wb_dat[7:0];

  // Transmit-side actions that start new work
  wire tx_on_rise = ctl_wr & wdat[USF_C_TXON] & ~ctl_r[USF_C_TXON];
  wire brk_wr = ctl_wr & wdat[USF_C_BRK];
  wire tc_act = data_wr | tx_on_rise | brk_wr;

  // Live status word
  wire [7:0] stat = {tx_buffer_empty_r, tc_r, rx_buffer_full_r, idle_r,
                     ovr_r, nf_r, fe_r, pf_r};

  // Clear strobes, each gated by the armed bit
  wire clr_tx_buffer_empty = data_wr & arm_r[USF_B_TX_BUFFER_EMPTY];
  wire clr_tc = tc_act & arm_r[USF_B_TC];
  wire clr_rx_buffer_full = data_rd & arm_r[USF_B_RX_BUFFER_FULL];
  wire clr_idle = data_rd & arm_r[USF_B_IDLE];
  wire clr_ovr = data_rd & arm_r[USF_B_OVR];
  wire clr_nf = data_rd & arm_r[USF_B_NF];
  wire clr_fe = data_rd & arm_r[USF_B_FE];
  wire clr_pf = data_rd & arm_r[USF_B_PF];

  // Set events
  // Work queued in this very cycle holds done off, so that an armed
  // clear is not undone by a set that sees the old idle state
  wire tc_set = tx_buffer_empty_r & ~i_tx_busy & ~queue_r & ~tc_act;
  // Character lands only when the buffer is free
  wire rx_take = i_rx_char & ~rx_buffer_full_r;
  wire ovr_set = i_rx_char & rx_buffer_full_r;
  wire par_exp = (^i_rx_data) ^ ctl_r[USF_C_PAR_ODD];
  wire par_bad = ctl_r[USF_C_PAR_EN] & (i_rx_par_bit != par_exp);
  wire noise_hit = noise_acc_r | (i_smp_valid & noisy_now);
  // Character time in bit times follows the length setting
  wire [3:0] idle_lim = ctl_r[USF_C_CHAR9] ? USF_IDLE_BITS9
                                           : USF_IDLE_BITS8;
  wire idle_hit = i_bit_tick & i_rxd & idle_en_r &
                  (idle_cnt_r == idle_lim - USF_CNT_ONE);
  wire idle_set = idle_hit & idle_allow_r;

  // Sample voter for the current bit
  usf_noise_vote u_vote (
    .i_smps(i_smps),
    .i_start_bit(i_smp_start),
    .o_noisy(noisy_now)
  );

  // Ack one cycle after the request, dropped the cycle after
  assign ack_nxt = bus_req & ~ack_r;

  // Read mux, unmapped offsets read as zero
  assign rdat_nxt = sel_stat ? {24'h000000, stat} :
                    sel_data ? {24'h000000, rx_data_r} :
                    sel_ctl ? {24'h000000, ctl_r} : USF_DAT_ZERO;

  // A status read arms exactly the flags it returned; data
  // accesses consume the arms that they used
  assign arm_nxt = stat_rd ? rdat_r[7:0] :
                   arm_r & ~{data_wr, tc_act, {6{data_rd}}};

  // Bus slave registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      rdat_r <= USF_DAT_ZERO;
    end else begin
      ack_r <= ack_nxt;
      // Data is captured with the ack and held while it stands
      rdat_r <= ack_nxt ? rdat_nxt : USF_DAT_ZERO;
    end
  end

  // Control register; writes to status change nothing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_r <= USF_CTRL_RST;
    end else if (ctl_wr) begin
      ctl_r <= wdat;
    end
  end

  // Transmit buffer write, one-cycle strobe to the shifter
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_data_r <= 8'h00;
      tx_wr_r <= 1'b0;
    end else begin
      tx_wr_r <= data_wr;
      if (data_wr) begin
        tx_data_r <= wdat;
      end
    end
  end

  // Clear arming
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arm_r <= 8'h00;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // Queued work holds done low until the transmitter picks it up;
  // without it, done would re-set before busy could rise
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      queue_r <= 1'b0;
    end else if (i_tx_busy) begin
      queue_r <= 1'b0;
    end else if (tc_act) begin
      queue_r <= 1'b1;
    end
  end

  // Transmit flags, set wins over clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_buffer_empty_r <= 1'b1;
      tc_r <= 1'b1;
    end else begin
      tx_buffer_empty_r <= i_tx_load | (tx_buffer_empty_r & ~clr_tx_buffer_empty);
      tc_r <= tc_set | (tc_r & ~clr_tc);
    end
  end

  // Receive buffer; an overrun character leaves it untouched
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_data_r <= 8'h00;
    end else if (rx_take) begin
      rx_data_r <= i_rx_data;
    end
  end

  // Receive flags; noise, framing and parity bits only follow characters taken
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buffer_full_r <= 1'b0;
      ovr_r <= 1'b0;
      nf_r <= 1'b0;
      fe_r <= 1'b0;
      pf_r <= 1'b0;
    end else begin
      rx_buffer_full_r <= rx_take | (rx_buffer_full_r & ~clr_rx_buffer_full);
      ovr_r <= ovr_set | (ovr_r & ~clr_ovr);
      nf_r <= (rx_take & noise_hit) | (nf_r & ~clr_nf);
      fe_r <= (rx_take & i_rx_stop_low) | (fe_r & ~clr_fe);
      pf_r <= (rx_take & par_bad) | (pf_r & ~clr_pf);
    end
  end

  // Noise collects over every bit; a start bit restarts it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      noise_acc_r <= 1'b0;
    end else if (i_smp_valid) begin
      noise_acc_r <= (i_smp_start ? 1'b0 : noise_acc_r) | noisy_now;
    end
  end

  // Idle counting enable by the count-after-stop setting
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_en_r <= 1'b0;
    end else if (i_start_det) begin
      idle_en_r <= ~ctl_r[USF_C_ILT];
    end else if (i_stop_done) begin
      idle_en_r <= 1'b1;
    end
  end

  // Idle bit counter; any low bit restarts it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_cnt_r <= USF_CNT_ZERO;
    end else if (i_start_det) begin
      idle_cnt_r <= USF_CNT_ZERO;
    end else if (i_stop_done & ctl_r[USF_C_ILT]) begin
      // Stop bit and trailing highs do not count
      idle_cnt_r <= USF_CNT_ZERO;
    end else if (i_bit_tick) begin
      if (!i_rxd) begin
        idle_cnt_r <= USF_CNT_ZERO;
      end else if (idle_en_r && idle_cnt_r != idle_lim) begin
        idle_cnt_r <= idle_cnt_r + USF_CNT_ONE;
      end
    end
  end

  // Quiet flag fires once per received character
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_allow_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      if (rx_take) begin
        idle_allow_r <= 1'b1;
      end else if (idle_set) begin
        idle_allow_r <= 1'b0;
      end
      idle_r <= idle_set | (idle_r & ~clr_idle);
    end
  end

  // Outputs straight from flip-flops
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  assign o_tx_data = tx_data_r;
  assign o_tx_wr = tx_wr_r;
  assign o_tx_on = ctl_r[USF_C_TXON];
  assign o_break_req = ctl_r[USF_C_BRK];
  assign o_char9 = ctl_r[USF_C_CHAR9];

  // Checks on the bus ack and the flag behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_req_new;
    bus_req && !ack_r;
  endsequence

  sequence s_ack_pulse;
    ack_r ##1 !ack_r;
  endsequence

  chk_bus_ack_once: assert property (s_req_new |=> s_ack_pulse)
    else $error("ack not a single cycle after request");

  chk_tx_buffer_empty_set_load: assert property (
    i_tx_load |=> tx_buffer_empty_r)
    else $error("transmit empty not set on buffer move");

  chk_tx_buffer_empty_clr_write: assert property (
    data_wr && arm_r[USF_B_TX_BUFFER_EMPTY] && !i_tx_load |=> !tx_buffer_empty_r)
    else $error("transmit empty not cleared by data write");

  chk_tc_set_idle: assert property (
    tx_buffer_empty_r && !i_tx_busy && !queue_r && !tc_act |=> tc_r)
    else $error("done not set while idle and empty");

  chk_tc_clr_act: assert property (
    tc_act && arm_r[USF_B_TC] && !tc_set
    |=> !tc_r ##1 (queue_r || i_tx_busy || !tc_r))
    else $error("done not cleared by queued work");

  chk_rx_buffer_full_clr_read: assert property (
    data_rd && arm_r[USF_B_RX_BUFFER_FULL] && !rx_take |=> !rx_buffer_full_r)
    else $error("receive full not cleared by data read");

  chk_ovr_keep_data: assert property (
    i_rx_char && rx_buffer_full_r |=> ovr_r && $stable(rx_data_r))
    else $error("overrun lost or buffer overwritten");

  chk_idle_needs_char: assert property (
    !idle_allow_r && !idle_r |=> !idle_r)
    else $error("quiet flag set without a new character");

  chk_idle_count_len: assert property (
    $rose(idle_r) |-> $past(idle_cnt_r) == idle_lim - USF_CNT_ONE)
    else $error("quiet flag set at wrong bit count");

  chk_fe_with_rx_buffer_full: assert property (
    rx_take && i_rx_stop_low |=> fe_r && rx_buffer_full_r)
    else $error("framing error not set with receive full");

  chk_pf_with_rx_buffer_full: assert property (
    rx_take && par_bad |=> pf_r && rx_buffer_full_r)
    else $error("parity error not set with receive full");

  chk_status_wr_none: assert property (
    wr_fire && sel_stat |=> $stable(arm_r) && $stable(ctl_r))
    else $error("status write had an effect");

  chk_arm_from_read: assert property (
    stat_rd |=> arm_r == $past(rdat_r[7:0]))
    else $error("arming differs from returned status");
endmodule
`default_nettype wire

// ===== usf_pkg.sv
/*
  Constants for the serial status-flag block: register offsets, flag bit
  positions, control field positions and character timing counts.
  Assumes a byte-addressed classic Wishbone slave with 32-bit data.
*/
package usf_pkg;
  // Register byte offsets
  localparam logic [7:0] USF_OFS_STATUS = 8'h00;
  localparam logic [7:0] USF_OFS_DATA = 8'h04;
  localparam logic [7:0] USF_OFS_CTRL = 8'h08;
  // Status flag bit positions
  localparam int USF_B_TX_BUFFER_EMPTY = 7;
  localparam int USF_B_TC = 6;
  localparam int USF_B_RX_BUFFER_FULL = 5;
  localparam int USF_B_IDLE = 4;
  localparam int USF_B_OVR = 3;
  localparam int USF_B_NF = 2;
  localparam int USF_B_FE = 1;
  localparam int USF_B_PF = 0;
  // Control register field positions
  localparam int USF_C_TXON = 0;
  localparam int USF_C_BRK = 1;
  localparam int USF_C_PAR_EN = 2;
  localparam int USF_C_PAR_ODD = 3;
  localparam int USF_C_CHAR9 = 4;
  localparam int USF_C_ILT = 5;
  // Reset values
  localparam logic [7:0] USF_CTRL_RST = 8'h00;
  localparam logic [31:0] USF_DAT_ZERO = 32'h00000000;
  // Idle bit-time counts for 8-bit and 9-bit characters
  localparam logic [3:0] USF_IDLE_BITS8 = 4'hA;
  localparam logic [3:0] USF_IDLE_BITS9 = 4'hB;
  localparam logic [3:0] USF_CNT_ONE = 4'h1;
  localparam logic [3:0] USF_CNT_ZERO = 4'h0;
endpackage

// ===== usf_noise_vote.sv
/*
  Sample agreement checker for one received bit.
  Assumes the receiver presents seven samples for the start bit and
  three samples, in the low bits, for every data and stop bit.
*/
`timescale 1ns/100ps
`default_nettype none
module usf_noise_vote (
  input wire logic [6:0] i_smps,
  input wire logic i_start_bit,
  output logic o_noisy
);
  // Samples that take part in the vote
  logic [6:0] use_mask;
  // Per-sample difference from the first sample
  logic [6:0] differs;

  // Start bit uses all seven, other bits only three
  assign use_mask = i_start_bit ? 7'h7F : 7'h07;

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_cmp
      assign differs[g] = use_mask[g] & (i_smps[g] ^ i_smps[0]);
    end
  endgenerate

  // Any disagreement within the bit marks it noisy
  assign o_noisy = |differs;
endmodule
`default_nettype wire

// ===== usf_far_end.sv
/*
  Far-end model: remote transmitter that delivers receive events, and
  the transmit shifter that drains the data buffer.
  Assumes the bench pulses i_send and holds the frame fields meanwhile.
*/
`timescale 1ns/100ps
`default_nettype none
module usf_far_end (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tx_wr,
  input wire logic i_tx_on,
  input wire logic i_brk,
  input wire logic i_send,
  input wire logic [7:0] i_data,
  input wire logic i_par,
  input wire logic i_stop_low,
  input wire logic i_noisy,
  output logic o_tx_load,
  output logic o_tx_busy,
  output logic o_rxd,
  output logic o_tick,
  output logic o_start,
  output logic o_stop,
  output logic o_sv,
  output logic o_ss,
  output logic [6:0] o_smps,
  output logic o_char,
  output logic [7:0] o_rdat,
  output logic o_rpar,
  output logic o_rlow
);
  logic [3:0] div_r; // Bit divider, 16 clocks a bit
  logic [3:0] bit_r; // Position in the frame
  logic [3:0] ix; // Data bit index
  logic act_r; // Frame in flight
  logic ton_r; // Previous transmitter enable
  logic dj_r; // Queued job carries data
  logic [5:0] wait_r; // Delay before the shifter starts
  logic [5:0] busy_r; // Shifter busy count
  logic job; // New work for the shifter
  assign ix = bit_r - 4'h1;
  assign job = i_tx_wr | (i_tx_on & ~ton_r) | i_brk;
  assign o_tx_busy = (busy_r != 6'h00);
  // Shifter is slow on purpose so busy and queued states are visible
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {div_r, bit_r, act_r, ton_r, dj_r, wait_r, busy_r} <= '0;
      {o_tx_load, o_tick, o_start, o_stop, o_sv, o_ss, o_char} <= '0;
      {o_smps, o_rdat, o_rpar, o_rlow} <= '0;
      o_rxd <= 1'h1;
    end else begin
      ton_r <= i_tx_on;
      o_tx_load <= 1'h0;
      // Break held high keeps queueing breaks
      if (job && wait_r == 6'h00 && busy_r == 6'h00) begin
        wait_r <= 6'h14;
        dj_r <= i_tx_wr;
      end else if (wait_r != 6'h00) begin
        wait_r <= wait_r - 6'h01;
      end
      if (wait_r == 6'h01) begin
        busy_r <= 6'h28;
        o_tx_load <= dj_r;
      end else if (busy_r != 6'h00) begin
        busy_r <= busy_r - 6'h01;
      end
      div_r <= div_r + 4'h1;
      o_tick <= (div_r == 4'hF);
      {o_start, o_stop, o_sv, o_ss, o_char} <= '0;
      if (i_send) begin
        act_r <= 1'h1;
        bit_r <= 4'h0;
      end
      if (div_r == 4'hF && act_r) begin
        bit_r <= bit_r + 4'h1;
        o_sv <= 1'h1;
        if (bit_r == 4'h0) begin // Seven start samples
          {o_rxd, o_start, o_ss} <= 3'h3;
          o_smps <= {6'h00, i_noisy};
        end else if (bit_r == 4'h9) begin // Ten-bit frame
          {o_rxd, o_stop, o_char} <= {~i_stop_low, 2'h3};
          act_r <= 1'h0;
          o_smps <= {4'h0, {3{~i_stop_low}}};
          {o_rdat, o_rpar, o_rlow} <= {i_data, i_par, i_stop_low};
        end else begin // Three samples a data bit
          o_rxd <= i_data[ix[2:0]];
          o_smps <= {4'h0, {3{i_data[ix[2:0]]}}};
        end
      end else if (!act_r) begin // Idle line sits high
        o_rxd <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== usf_status_flags_test.sv
/*
  Self-checking bench for the serial status flags over Wishbone.
  Assumes the far-end model ticks every 16 clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module usf_status_flags_test;
  import usf_pkg::*;
  typedef struct packed {
    logic [7:0] c; // Control value
    logic [7:0] d; // Frame data
    logic p; // Parity bit sent
    logic l; // Stop bit low
    logic z; // Noisy start bit
    logic [7:0] s; // Status right after the frame
  } usf_row_t;
  logic clk = 1'h0;
  logic rstn = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, send = 1'h0;
  logic fpar = 1'h0, flow = 1'h0, fnz = 1'h0;
  logic [7:0] adr = 8'h00, fdat = 8'h00, txd, rdt;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, ld, bsy, txwr, ton, brk, c9, rxd, tk, sd, stp, sv, ss;
  logic rch, rpar, rlow;
  logic [6:0] smp;
  int num_errors = 0;
  int n_checks = 0;
  usf_row_t rows [8] = '{
    '{8'h00, 8'h55, 1'h0, 1'h0, 1'h0, 8'hE0},
    '{8'h00, 8'hA5, 1'h0, 1'h0, 1'h1, 8'hE4},
    '{8'h00, 8'h3C, 1'h0, 1'h1, 1'h0, 8'hE2},
    '{8'h04, 8'h01, 1'h0, 1'h0, 1'h0, 8'hE1},
    '{8'h0C, 8'h01, 1'h0, 1'h0, 1'h0, 8'hE0},
    '{8'h04, 8'h03, 1'h0, 1'h0, 1'h0, 8'hE0},
    '{8'h00, 8'h01, 1'h0, 1'h0, 1'h0, 8'hE0},
    '{8'h04, 8'h01, 1'h0, 1'h1, 1'h1, 8'hE7}
  };
  usf_status_flags i_dut (
    .i_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_tx_load(ld), .i_tx_busy(bsy),
    .o_tx_data(txd), .o_tx_wr(txwr), .o_tx_on(ton), .o_break_req(brk),
    .o_char9(c9), .i_rxd(rxd), .i_bit_tick(tk), .i_start_det(sd),
    .i_stop_done(stp), .i_smp_valid(sv), .i_smp_start(ss),
    .i_smps(smp), .i_rx_char(rch), .i_rx_data(rdt),
    .i_rx_par_bit(rpar), .i_rx_stop_low(rlow)
  );
  usf_far_end i_far (
    .i_clk(clk), .i_resetn(rstn), .i_tx_wr(txwr), .i_tx_on(ton),
    .i_brk(brk), .i_send(send), .i_data(fdat), .i_par(fpar),
    .i_stop_low(flow), .i_noisy(fnz), .o_tx_load(ld), .o_tx_busy(bsy),
    .o_rxd(rxd), .o_tick(tk), .o_start(sd), .o_stop(stp), .o_sv(sv),
    .o_ss(ss), .o_smps(smp), .o_char(rch), .o_rdat(rdt),
    .o_rpar(rpar), .o_rlow(rlow)
  );
  // 25 ns period
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One classic cycle; held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    int n;
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h0, d};
    @(posedge clk);
    for (n = 0; n < 20 && ack !== 1'h1; n++) @(posedge clk);
    if (ack !== 1'h1) num_errors++;
    r = rdat;
    {cyc, stb, we} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Status then data read with no compare, to leave a clean state
  task automatic clr;
    bus(1'h0, USF_OFS_STATUS, 8'h00, q);
    bus(1'h0, USF_OFS_DATA, 8'h00, q);
  endtask
  // Sends one frame and returns one clock after it is handed over
  task automatic frame(input logic [7:0] d, input logic p, l, z);
    int n;
    {fdat, fpar, flow, fnz, send} <= {d, p, l, z, 1'h1};
    @(posedge clk);
    send <= 1'h0;
    for (n = 0; n < 400 && rch !== 1'h1; n++) @(posedge clk);
    if (rch !== 1'h1) num_errors++;
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Run needs about 5000 clocks; this is well beyond
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial begin
    rstn = 1'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(USF_OFS_STATUS, 32'hC0);
    rd(8'h0C, 32'h0);
    wr(USF_OFS_DATA, 8'h5A);
    rd(USF_OFS_STATUS, 32'h00);
    chk({24'h0, txd}, 32'h5A);
    idle(30);
    rd(USF_OFS_STATUS, 32'h80);
    idle(60);
    rd(USF_OFS_STATUS, 32'hC0);
    wr(USF_OFS_CTRL, 8'h01);
    rd(USF_OFS_STATUS, 32'h80);
    idle(80);
    rd(USF_OFS_STATUS, 32'hC0);
    wr(USF_OFS_CTRL, 8'h03);
    wr(USF_OFS_CTRL, 8'h01);
    rd(USF_OFS_STATUS, 32'h80);
    idle(80);
    rd(USF_OFS_STATUS, 32'hC0);
    $display("transmit flags done");
    foreach (rows[i]) begin
      wr(USF_OFS_CTRL, rows[i].c);
      frame(rows[i].d, rows[i].p, rows[i].l, rows[i].z);
      rd(USF_OFS_STATUS, {24'h0, rows[i].s});
      rd(USF_OFS_DATA, {24'h0, rows[i].d});
      idle(200);
      rd(USF_OFS_STATUS, 32'hD0);
      rd(USF_OFS_DATA, {24'h0, rows[i].d});
      rd(USF_OFS_STATUS, 32'hC0);
      $display("row %0d done", i);
    end
    idle(300);
    rd(USF_OFS_STATUS, 32'hC0);
    frame(8'h81, 1'h0, 1'h0, 1'h0);
    rd(USF_OFS_DATA, 32'h81);
    rd(USF_OFS_STATUS, 32'hE0);
    wr(USF_OFS_STATUS, 8'h00);
    rd(USF_OFS_STATUS, 32'hE0);
    frame(8'h42, 1'h0, 1'h1, 1'h1);
    rd(USF_OFS_STATUS, 32'hE8);
    rd(USF_OFS_DATA, 32'h81);
    rd(USF_OFS_STATUS, 32'hC0);
    $display("overrun done");
    idle(300);
    clr();
    wr(USF_OFS_CTRL, 8'h00);
    frame(8'hFF, 1'h0, 1'h0, 1'h0);
    idle(40);
    rd(USF_OFS_STATUS, 32'hF0);
    clr();
    wr(USF_OFS_CTRL, 8'h30);
    frame(8'hFF, 1'h0, 1'h0, 1'h0);
    idle(40);
    rd(USF_OFS_STATUS, 32'hE0);
    idle(120);
    rd(USF_OFS_STATUS, 32'hE0);
    idle(30);
    rd(USF_OFS_STATUS, 32'hF0);
    $display("idle count done");
    rstn <= 1'h0;
    idle(3);
    rstn <= 1'h1;
    idle(1);
    rd(USF_OFS_STATUS, 32'hC0);
    chk({31'h0, c9}, 32'h0);
    $display("reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
